// ===== design/afcc_map.svh
// register indices, field positions, reset values and timing counts of the config bank
`ifndef AFCC_MAP_SVH
`define AFCC_MAP_SVH
// ===========================================================================
// register indices (byte address is four times the index)
`define AFCC_IDX_TGR        6'h33
`define AFCC_IDX_RATE       6'h34
`define AFCC_IDX_SYNC       6'h35
`define AFCC_IDX_MISC       6'h36
`define AFCC_IDX_IRQ_STAT   6'h3C
`define AFCC_IDX_IRQ_MASK   6'h3D
`define AFCC_IDX_STATUS     6'h3E
`define AFCC_IDX_GLOBAL     6'h3F
// ===========================================================================
// reset values
`define AFCC_RST_TGR        8'h00
`define AFCC_RST_RATE       8'hC8
`define AFCC_RST_SYNC       8'h01
`define AFCC_RST_MISC       8'h00
`define AFCC_RST_GLOBAL     1'h1
`define AFCC_RST_IRQ        3'h0
// ===========================================================================
// field positions
`define AFCC_IRQ_LOSS_BIT   0
`define AFCC_IRQ_DOWN_BIT   1
`define AFCC_IRQ_UP_BIT     2
`define AFCC_STAT_LOST_BIT  8
// ===========================================================================
// tone rate scaling, centihertz
`define AFCC_TONE_DEFAULT   8'hC8
`define AFCC_TONE_STEP_CHZ  22'h00249F
`define AFCC_TONE_DEF_CHZ   22'h1C9C38
`define AFCC_TONE_MAX_CHZ   22'h247A61
// ===========================================================================
// timing
`define AFCC_CLK_NS          25
`define AFCC_ZC_BASE_NS      20000
`define AFCC_ZC_BASE_CYC     (`AFCC_ZC_BASE_NS / `AFCC_CLK_NS)
`define AFCC_ATTACK_BASE_MS  100
`define AFCC_ATTACK_BASE_CYC (`AFCC_ATTACK_BASE_MS * 1000000 / `AFCC_CLK_NS)
`define AFCC_RELEASE_BASE_MS 200
`define AFCC_RELEASE_BASE_CYC (`AFCC_RELEASE_BASE_MS * 1000000 / `AFCC_CLK_NS)
`define AFCC_WD_STEP_NS      2500
`define AFCC_WD_STEP_CYC     16'((`AFCC_WD_STEP_NS) / `AFCC_CLK_NS)
`define AFCC_WD_LOW3_NS      10000
`define AFCC_WD_LOW3_CYC     16'((`AFCC_WD_LOW3_NS) / `AFCC_CLK_NS)
`endif

// ===== design/afcc_pkg.sv
// types of the foldback and clock config bank
package afcc_pkg;
  typedef enum logic [2:0] {
    AFCC_F_2M1  = 3'b000,
    AFCC_F_2M3  = 3'b001,
    AFCC_F_576K = 3'b010,
    AFCC_F_384K = 3'b011,
    AFCC_F_460K = 3'b100
  } afcc_freq_t;
  typedef enum logic [1:0] {
    AFCC_FB_IDLE   = 2'b00,
    AFCC_FB_TIMING = 2'b01,
    AFCC_FB_WAIT   = 2'b10
  } afcc_fb_state_t;
  typedef struct packed {
    logic [1:0] zc_wait;
    logic       fb_off;
    logic       zc_skip;
    logic [1:0] attack;
    logic [1:0] rel;
  } afcc_tgr_t;
  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] wd_code;
    logic       chk_skip;
    logic       master;
  } afcc_sync_t;
  typedef struct packed {
    logic       rsvd;
    logic       tri_level;
    logic [1:0] spread_ctrl_four;
    logic       sync_spread_off;
    logic [2:0] pwm_freq;
  } afcc_misc_t;
  typedef struct packed {
    logic       master;
    logic       spread_on;
    logic       tri_level;
    logic       mute;
    afcc_freq_t freq;
  } afcc_cfg_t;
endpackage

// ===== design/afcc_regs.sv
// foldback, diagnostic tone and switching clock config bank with AXI4-Lite slave
// Behaviour
// [RULE1] gain step waits for zero crossing at most 20/80/320/1280 us, then applies
// [RULE2] foldback control bit 5 set turns thermal gain reduction off
// [RULE3] zero-cross skip applies each gain step at once without waiting
// [RULE4] while reducing, gain drops 1 dB per 100/200/400/800 ms interval
// [RULE5] while restoring, gain rises 1 dB per 200/400/800/1600 ms interval
// [RULE6] tone rate code scales 93.75 Hz per step; reset code 200
// [RULE7] tone rate code zero is treated as the 18.75 kHz default
// [RULE8] at 2.1/2.3 MHz the loss timeout is 2.5/5/7.5/10 us
// [RULE9] at 384/460/576 kHz the loss timeout is 5/10/15/10 us
// [RULE10] clock check skip bit set disables sync clock error detection
// [RULE11] in slave mode the host routes an external sync clock to a pin
// [RULE12] master mode makes the switching clock internally; reset state is master
// [RULE13] tri-level standby makes a mid level on the standby pin mute
// [RULE14] in slave mode spread applies to sync input unless its bypass bit set
// [RULE15] frequency code selects 2.1M, 2.3M, 576k, 384k, 460k for codes 0-4
// [RULE16] global spread enable turns modulation on, resets enabled
// [RULE17] watchdog restarts on each sync edge, flags loss on timeout while active
// [RULE18] frequency codes 5-7 fall back to a defined frequency
`include "afcc_map.svh"
module afcc_regs #(
  parameter int unsigned MAX_ATTEN_DB     = 24,
  parameter int unsigned ZC_BASE_CYC      = `AFCC_ZC_BASE_CYC,
  parameter int unsigned ATTACK_BASE_CYC  = `AFCC_ATTACK_BASE_CYC,
  parameter int unsigned RELEASE_BASE_CYC = `AFCC_RELEASE_BASE_CYC
) (
  input  logic              aclk,
  input  logic              aresetn,
  input  logic              ce,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [7:0]        s_axi_awaddr,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  input  logic [7:0]        s_axi_araddr,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  input  logic              thermal_hot,
  input  logic              zero_cross,
  input  logic              sync_in,
  input  logic              standby_mid,
  output logic              irq,
  output logic [7:0]        gain_reduction_db,
  output logic              ext_clock_lost,
  output logic [7:0]        diag_tone_rate,
  output logic [21:0]       tone_freq_chz,
  output afcc_pkg::afcc_cfg_t cfg_out
);
  import afcc_pkg::*;

  // the longest zero-cross wait is the base shifted by six and must fit the 16-bit counter
  if (MAX_ATTEN_DB > 255 || MAX_ATTEN_DB == 0 || ZC_BASE_CYC == 0 || ZC_BASE_CYC > 1023 ||
      ATTACK_BASE_CYC == 0 || RELEASE_BASE_CYC == 0 ||
      ATTACK_BASE_CYC > 32'h0FFFFFFF || RELEASE_BASE_CYC > 32'h0FFFFFFF) begin : g_bad_param
    $error("afcc_regs: parameter values out of range");
  end

  // ==========================================================================
  // functions
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= `AFCC_IDX_TGR && idx <= `AFCC_IDX_MISC) ||
                (idx >= `AFCC_IDX_IRQ_STAT && idx <= `AFCC_IDX_GLOBAL);
  endfunction

  function automatic logic [31:0] cyc_shift(input int unsigned base, input logic [2:0] sh);
    cyc_shift = 32'(base) << sh;
  endfunction

  function automatic logic [15:0] wd_limit(input logic [1:0] code, input logic low_rate);
    logic [15:0] steps;
    steps = 16'({14'h0000, code} + 16'h0001);
    if (!low_rate) begin
      wd_limit = 16'(steps * `AFCC_WD_STEP_CYC);
    end else if (code == 2'h3) begin
      wd_limit = `AFCC_WD_LOW3_CYC;
    end else begin
      wd_limit = 16'(steps * `AFCC_WD_STEP_CYC * 16'h0002);
    end
  endfunction

  // ==========================================================================
  // AXI4-Lite write channel
  afcc_tgr_t   thermal_gain_reduction_ctrl_reg;
  logic [7:0]  ac_diag_tone_rate_reg;
  afcc_sync_t  clock_follow_ctrl_reg;
  afcc_misc_t  switching_misc_ctrl_reg;
  logic        spread_enable_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_mask_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [5:0]  aw_idx_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        wr_go;
  logic        wr_en;

  assign s_axi_awready = ce && !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = ce && !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_go = ce && aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_en = wr_go && wstrb0_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_idx_reg  <= 6'h00;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= is_mapped(aw_idx_reg) ? 2'h0 : 2'h2;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_gain_reduction_ctrl_reg <= `AFCC_RST_TGR;
      ac_diag_tone_rate_reg           <= `AFCC_RST_RATE; // [RULE6]
      clock_follow_ctrl_reg           <= `AFCC_RST_SYNC; // [RULE12]
      switching_misc_ctrl_reg         <= `AFCC_RST_MISC;
      spread_enable_reg               <= `AFCC_RST_GLOBAL; // [RULE16]
      irq_mask_reg                    <= `AFCC_RST_IRQ;
    end else if (wr_en) begin
      case (aw_idx_reg)
        `AFCC_IDX_TGR:      thermal_gain_reduction_ctrl_reg <= wdata_reg;
        `AFCC_IDX_RATE:     ac_diag_tone_rate_reg <= wdata_reg;
        `AFCC_IDX_SYNC:     clock_follow_ctrl_reg <= wdata_reg;
        `AFCC_IDX_MISC:     switching_misc_ctrl_reg <= wdata_reg;
        `AFCC_IDX_IRQ_MASK: irq_mask_reg <= wdata_reg[2:0];
        `AFCC_IDX_GLOBAL:   spread_enable_reg <= wdata_reg[0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // thermal gain foldback
  afcc_fb_state_t fb_state_reg;
  logic [31:0]    ivl_cnt_reg;
  logic [15:0]    zc_cnt_reg;
  logic           dir_down_reg;
  logic [7:0]     atten_reg;
  logic           step_down_evt_reg;
  logic           step_up_evt_reg;
  logic           need_down;
  logic           need_up;
  logic [31:0]    ivl_lim;
  logic [15:0]    zc_lim;
  logic           ivl_done;
  logic           apply_now;
  logic           apply_down;

  assign need_down = thermal_hot && atten_reg < 8'(MAX_ATTEN_DB);
  assign need_up   = !thermal_hot && atten_reg != 8'h00;
  // attack and release intervals double per code step
  assign ivl_lim = need_down ?
                   cyc_shift(ATTACK_BASE_CYC, {1'b0, thermal_gain_reduction_ctrl_reg.attack}) :
                   cyc_shift(RELEASE_BASE_CYC, {1'b0, thermal_gain_reduction_ctrl_reg.rel});
  // zero-cross wait quadruples per code step
  assign zc_lim = 16'(cyc_shift(ZC_BASE_CYC, {thermal_gain_reduction_ctrl_reg.zc_wait, 1'b0}));
  assign ivl_done = fb_state_reg == AFCC_FB_TIMING && (need_down || need_up) &&
                    ivl_cnt_reg == ivl_lim - 32'h1; // [RULE4] [RULE5]
  assign apply_now = !thermal_gain_reduction_ctrl_reg.fb_off &&
                     ((ivl_done && (thermal_gain_reduction_ctrl_reg.zc_skip || zero_cross)) ||
                      (fb_state_reg == AFCC_FB_WAIT &&
                       (thermal_gain_reduction_ctrl_reg.zc_skip || zero_cross ||
                        zc_cnt_reg == zc_lim - 16'h1))); // [RULE1] [RULE3]
  assign apply_down = fb_state_reg == AFCC_FB_TIMING ? need_down : dir_down_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_state_reg <= AFCC_FB_IDLE;
      ivl_cnt_reg  <= 32'h0;
      zc_cnt_reg   <= 16'h0;
      dir_down_reg <= 1'b0;
    end else if (ce) begin
      if (thermal_gain_reduction_ctrl_reg.fb_off) begin
        fb_state_reg <= AFCC_FB_IDLE; // [RULE2]
        ivl_cnt_reg  <= 32'h0;
        zc_cnt_reg   <= 16'h0;
      end else begin
        case (fb_state_reg)
          AFCC_FB_IDLE: begin
            ivl_cnt_reg <= 32'h0;
            if (need_down || need_up) begin
              fb_state_reg <= AFCC_FB_TIMING;
            end
          end
          AFCC_FB_TIMING: begin
            if (!(need_down || need_up)) begin
              fb_state_reg <= AFCC_FB_IDLE;
            end else if (ivl_done) begin
              ivl_cnt_reg  <= 32'h0;
              zc_cnt_reg   <= 16'h0;
              dir_down_reg <= need_down;
              if (!apply_now) begin
                fb_state_reg <= AFCC_FB_WAIT;
              end
            end else begin
              ivl_cnt_reg <= ivl_cnt_reg + 32'h1;
            end
          end
          AFCC_FB_WAIT: begin
            if (apply_now) begin
              fb_state_reg <= AFCC_FB_TIMING; // [RULE1]
            end else begin
              zc_cnt_reg <= zc_cnt_reg + 16'h1;
            end
          end
          default: fb_state_reg <= AFCC_FB_IDLE;
        endcase
      end
    end
  end

  // gain steps are bounded again here because the heat input may flip while waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      atten_reg         <= 8'h00;
      step_down_evt_reg <= 1'b0;
      step_up_evt_reg   <= 1'b0;
    end else if (ce) begin
      step_down_evt_reg <= 1'b0;
      step_up_evt_reg   <= 1'b0;
      if (thermal_gain_reduction_ctrl_reg.fb_off) begin
        atten_reg <= 8'h00; // [RULE2]
      end else if (apply_now && apply_down && atten_reg < 8'(MAX_ATTEN_DB)) begin
        atten_reg         <= atten_reg + 8'h01; // [RULE4]
        step_down_evt_reg <= 1'b1;
      end else if (apply_now && !apply_down && atten_reg != 8'h00) begin
        atten_reg       <= atten_reg - 8'h01; // [RULE5]
        step_up_evt_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // sync clock watchdog
  logic        sync_prev_reg;
  logic [15:0] wd_cnt_reg;
  logic        lost_reg;
  logic        loss_evt_reg;
  logic        sync_edge;
  logic        wd_on;
  logic        low_rate;
  logic [15:0] wd_lim;
  afcc_freq_t  freq_eff;

  // undefined codes run at the reset frequency rather than an arbitrary one
  assign freq_eff = switching_misc_ctrl_reg.pwm_freq > 3'h4 ? AFCC_F_2M1 :
                    afcc_freq_t'(switching_misc_ctrl_reg.pwm_freq); // [RULE15] [RULE18]
  assign low_rate  = freq_eff != AFCC_F_2M1 && freq_eff != AFCC_F_2M3;
  assign wd_lim    = wd_limit(clock_follow_ctrl_reg.wd_code, low_rate); // [RULE8] [RULE9]
  assign sync_edge = sync_in && !sync_prev_reg;
  // only a slave follows an outside clock, so only a slave can lose it
  assign wd_on = !clock_follow_ctrl_reg.master && !clock_follow_ctrl_reg.chk_skip; // [RULE10]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev_reg <= 1'b0;
      wd_cnt_reg    <= 16'h0;
      lost_reg      <= 1'b0;
      loss_evt_reg  <= 1'b0;
    end else if (ce) begin
      sync_prev_reg <= sync_in;
      loss_evt_reg  <= 1'b0;
      if (!wd_on || sync_edge) begin
        wd_cnt_reg <= 16'h0; // [RULE17]
        lost_reg   <= 1'b0;
      end else if (wd_cnt_reg >= wd_lim - 16'h1) begin
        wd_cnt_reg   <= 16'h0;
        lost_reg     <= 1'b1; // [RULE17]
        loss_evt_reg <= !lost_reg;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 16'h1;
      end
    end
  end

  // ==========================================================================
  // interrupt status, write one to clear; a new event beats the clear
  logic [2:0] evt_vec;
  logic [2:0] w1c_vec;

  assign evt_vec = {step_up_evt_reg, step_down_evt_reg, loss_evt_reg};
  assign w1c_vec = (wr_en && aw_idx_reg == `AFCC_IDX_IRQ_STAT) ? wdata_reg[2:0] : 3'h0;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= `AFCC_RST_IRQ;
    end else if (ce) begin
      irq_stat_reg <= (irq_stat_reg & ~w1c_vec) | evt_vec;
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_out        <= '{master: 1'b1, spread_on: 1'b1, tri_level: 1'b0, mute: 1'b0,
                          freq: AFCC_F_2M1};
      diag_tone_rate <= `AFCC_TONE_DEFAULT;
      tone_freq_chz  <= `AFCC_TONE_DEF_CHZ;
    end else if (ce) begin
      cfg_out.master    <= clock_follow_ctrl_reg.master; // [RULE12]
      cfg_out.spread_on <= spread_enable_reg && (clock_follow_ctrl_reg.master ||
                           !switching_misc_ctrl_reg.sync_spread_off); // [RULE14] [RULE16]
      cfg_out.tri_level <= switching_misc_ctrl_reg.tri_level;
      cfg_out.mute      <= switching_misc_ctrl_reg.tri_level && standby_mid; // [RULE13]
      cfg_out.freq      <= freq_eff; // [RULE15]
      if (ac_diag_tone_rate_reg == 8'h00) begin
        diag_tone_rate <= `AFCC_TONE_DEFAULT; // [RULE7]
        tone_freq_chz  <= `AFCC_TONE_DEF_CHZ;
      end else begin
        diag_tone_rate <= ac_diag_tone_rate_reg;
        tone_freq_chz  <= 22'({14'h0000, ac_diag_tone_rate_reg} * `AFCC_TONE_STEP_CHZ); // [RULE6]
      end
    end
  end

  assign gain_reduction_db = atten_reg;
  assign ext_clock_lost    = lost_reg;

  // ==========================================================================
  // read channel
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_mux;
  logic [5:0]  ar_idx;

  assign ar_idx        = s_axi_araddr[7:2];
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    rd_mux = 32'h0;
    case (ar_idx)
      `AFCC_IDX_TGR:      rd_mux = {24'h0, thermal_gain_reduction_ctrl_reg};
      `AFCC_IDX_RATE:     rd_mux = {24'h0, ac_diag_tone_rate_reg};
      `AFCC_IDX_SYNC:     rd_mux = {24'h0, clock_follow_ctrl_reg};
      `AFCC_IDX_MISC:     rd_mux = {24'h0, switching_misc_ctrl_reg};
      `AFCC_IDX_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
      `AFCC_IDX_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
      `AFCC_IDX_STATUS:   rd_mux = {20'h0, freq_eff, lost_reg, atten_reg};
      `AFCC_IDX_GLOBAL:   rd_mux = {31'h0, spread_enable_reg};
      default:            rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= 2'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= is_mapped(ar_idx) ? 2'h0 : 2'h2;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fb_off_clears_a: assert property (ce && thermal_gain_reduction_ctrl_reg.fb_off |=> // [RULE2]
      atten_reg == 8'h00 && fb_state_reg == AFCC_FB_IDLE)
    else $error("foldback off did not clear gain reduction");
  zc_timeout_a: assert property (ce && fb_state_reg == AFCC_FB_WAIT && // [RULE1]
      !thermal_gain_reduction_ctrl_reg.fb_off && zc_cnt_reg == zc_lim - 16'h1 |=>
      fb_state_reg == AFCC_FB_TIMING)
    else $error("gain step not applied at zero-cross timeout");
  skip_immediate_a: assert property (ce && ivl_done && // [RULE3]
      thermal_gain_reduction_ctrl_reg.zc_skip && !thermal_gain_reduction_ctrl_reg.fb_off &&
      need_down |=> atten_reg == $past(atten_reg) + 8'h01 && step_down_evt_reg)
    else $error("skipped zero cross did not step at once");
  attack_base_a: assert property (need_down && // [RULE4]
      thermal_gain_reduction_ctrl_reg.attack == 2'h3 |-> ivl_lim == 32'(ATTACK_BASE_CYC) * 8)
    else $error("attack interval wrong");
  release_base_a: assert property (need_up && // [RULE5]
      thermal_gain_reduction_ctrl_reg.rel == 2'h1 |-> ivl_lim == 32'(RELEASE_BASE_CYC) * 2)
    else $error("release interval wrong");
  tone_scale_a: assert property (ce && ac_diag_tone_rate_reg == 8'hFF |=> // [RULE6]
      tone_freq_chz == `AFCC_TONE_MAX_CHZ)
    else $error("tone rate scale wrong");
  tone_zero_a: assert property (ce && ac_diag_tone_rate_reg == 8'h00 |=> // [RULE7]
      tone_freq_chz == `AFCC_TONE_DEF_CHZ && diag_tone_rate == `AFCC_TONE_DEFAULT)
    else $error("zero tone code not mapped to default");
  wd_fast_a: assert property (!low_rate && clock_follow_ctrl_reg.wd_code == 2'h2 |-> // [RULE8]
      wd_lim == 16'h012C)
    else $error("fast-rate watchdog limit wrong");
  wd_slow_a: assert property (low_rate && clock_follow_ctrl_reg.wd_code == 2'h3 |-> // [RULE9]
      wd_lim == 16'h0190)
    else $error("slow-rate watchdog code 3 limit wrong");
  wd_skip_quiet_a: assert property (ce && !wd_on |=> !loss_evt_reg && !lost_reg) // [RULE10]
    else $error("sync loss flagged while detection inactive");
  wd_restart_a: assert property (ce && sync_edge |=> wd_cnt_reg == 16'h0 && !lost_reg) // [RULE17]
    else $error("sync edge did not restart watchdog");
  spread_on_a: assert property (ce && !clock_follow_ctrl_reg.master && spread_enable_reg && // [RULE14]
      switching_misc_ctrl_reg.sync_spread_off |=> !cfg_out.spread_on)
    else $error("sync spread bypass ignored");
  mute_mid_a: assert property (ce && switching_misc_ctrl_reg.tri_level && standby_mid |=> // [RULE13]
      cfg_out.mute)
    else $error("mid level did not mute");
  freq_defined_a: assert property (cfg_out.freq <= AFCC_F_460K) // [RULE18]
    else $error("undefined switching frequency driven");
  loss_irq_a: assert property (ce && loss_evt_reg |=> irq_stat_reg[`AFCC_IRQ_LOSS_BIT])
    else $error("loss event lost under clear");
endmodule

// ===== verification/afcc_sync_src.sv
// external sync clock source that feeds the bank in slave mode
module afcc_sync_src (
  input  logic aclk,
  input  logic run,
  output logic sync_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg = 4'h0;
  logic       sync_reg = 1'b0;
  assign sync_in = sync_reg;
  // period of 16 cycles; the line stands low once stopped, so loss is seen
  always @(posedge aclk) begin
    cnt_reg <= cnt_reg + 4'h1;
    sync_reg <= run & cnt_reg[3];
  end
endmodule

// ===== verification/test_afcc_regs.sv
// self-checking bench of the foldback and clock config bank
module test_afcc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import afcc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, run = 1'b0, zero_cross = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, thermal_hot = 1'b0;
  logic standby_mid = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq, ext_clock_lost, sync_in;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [7:0] gain_reduction_db, diag_tone_rate;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [21:0] tone_freq_chz;
  afcc_cfg_t cfg_out;
  int bad_count = 0, comparisons = 0, c;
  always #12.5 aclk = ~aclk;
  // short interval counts keep the run small
  afcc_regs #(.ZC_BASE_CYC(8), .ATTACK_BASE_CYC(40), .RELEASE_BASE_CYC(80)) afcc_regs_inst (.*);
  afcc_sync_src afcc_sync_src_inst (.aclk(aclk), .run(run), .sync_in(sync_in));
  // ==========================================================================
  // helpers
  function automatic logic [21:0] tone(input logic [7:0] k);
    return (k == 8'h00 ? 22'h0000C8 : 22'(k)) * 22'h00249F;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, er);
  endtask
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang counts as a failure
  initial begin
    #1ms;
    bad_count++;
    conclude();
  end
  // ==========================================================================
  // tests
  initial begin
    void'($urandom(32'h1158dd39));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk(cfg_out, 7'h60);
    rd(8'hCC, 8'h00, 2'h0);
    rd(8'hD0, 8'hC8, 2'h0);
    rd(8'hD4, 8'h01, 2'h0);
    rd(8'hD8, 8'h00, 2'h0);
    rd(8'hFC, 8'h01, 2'h0);
    rd(8'h00, 8'h00, 2'h2);
    wr(8'h20, 8'h55, 2'h2);
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? i * 255 : $urandom_range(255);
      wr(8'hD0, 8'(c), 2'h0);
      repeat (2) @(posedge aclk);
      chk(tone_freq_chz, tone(8'(c)));
      chk(diag_tone_rate, (c == 0) ? 8'hC8 : 8'(c));
    end
    // a write with its low strobe clear must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(8'hD0, ~8'(c), 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'hD0, 8'(c), 2'h0);
    wr(8'hD4, 8'h0D, 2'h0);
    for (int f = 0; f < 8; f++) begin
      standby_mid <= 1'($urandom);
      wr(8'hD8, 8'(f) | 8'h40, 2'h0);
      repeat (2) @(posedge aclk);
      chk(cfg_out.freq, (f > 4) ? 0 : f);
      chk(cfg_out.mute, standby_mid);
    end
    c = $urandom_range(3);
    wr(8'hF4, 8'h01, 2'h0);
    run <= 1'b1;
    wr(8'hD4, 8'(c << 2), 2'h0);
    repeat (300) @(posedge aclk);
    chk(ext_clock_lost, 1'b0);
    run <= 1'b0;
    // last sync edge lies up to 16 cycles back, hence the margins
    repeat (100 * c + 80) @(posedge aclk);
    chk(ext_clock_lost, 1'b0);
    repeat (25) @(posedge aclk);
    chk(ext_clock_lost, 1'b1);
    chk(irq, 1'b1);
    rd(8'hF0, 8'h01, 2'h0);
    wr(8'hF4, 8'h00, 2'h0);
    chk(irq, 1'b0);
    wr(8'hF0, 8'h01, 2'h0);
    wr(8'hF4, 8'h01, 2'h0);
    chk(irq, 1'b0);
    wr(8'hD8, 8'h08, 2'h0);
    repeat (2) @(posedge aclk);
    chk(cfg_out, 7'h00);
    wr(8'hD4, 8'h02, 2'h0);
    repeat (2) @(posedge aclk);
    chk(ext_clock_lost, 1'b0);
    wr(8'hCC, 8'h10, 2'h0);
    thermal_hot <= 1'b1;
    repeat (100) @(posedge aclk);
    chk(gain_reduction_db, 8'h02);
    thermal_hot <= 1'b0;
    repeat (100) @(posedge aclk);
    chk(gain_reduction_db, 8'h01);
    wr(8'hCC, 8'h30, 2'h0);
    repeat (2) @(posedge aclk);
    chk(gain_reduction_db, 8'h00);
    // slowest attack, release code 1, zero-cross wait of 8 cycles, no skip
    wr(8'hCC, 8'h0D, 2'h0);
    thermal_hot <= 1'b1;
    repeat (324) @(posedge aclk);
    chk(gain_reduction_db, 8'h00);
    repeat (8) @(posedge aclk);
    chk(gain_reduction_db, 8'h01);
    repeat (318) @(posedge aclk);
    zero_cross <= 1'b1;
    @(posedge aclk);
    zero_cross <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(gain_reduction_db, 8'h02);
    thermal_hot <= 1'b0;
    repeat (2) @(posedge aclk);
    conclude();
  end
endmodule
